// ### design/dot_pages.sv
/*
  Dot control register pages: on/off bank, open and short flag banks,
  duty bank, per-dot mode selector bank, the locked page selector and a
  row scan slot timer. Assumes a serial protocol engine upstream that turns
  bus transfers into one-cycle byte strobes, a detection engine that posts
  fault results, and a scan engine that fetches dot data by index.
*/
`timescale 1ns/1ns
`default_nettype none

module dot_pages #(
  parameter int ACTIVE_CYCLES = dot_pages_pkg::ACTIVE_CYC // shorten in simulation
) (
  input wire logic core_clk_i,                        // core clock, 100 MHz
  input wire logic rst_i,                             // synchronous reset, active high
  input wire dot_pages_pkg::reg_req_t reg_req_i,      // register byte strobes
  output logic [7:0] reg_rdata_o,                     // read data, one cycle after rd
  output logic reg_rvalid_o,                          // read data valid pulse
  output logic [7:0] page_selector_o,                 // current page code
  input wire dot_pages_pkg::fault_rpt_t fault_rpt_i,  // detection run results
  input wire logic breath_en_i,                       // global breathing enable
  input wire logic [7:0] scan_idx_i,                  // byte index fetched by scan
  output logic [7:0] scan_onoff_o,                    // on/off byte at index
  output logic [7:0] scan_duty_o,                     // duty byte at index
  output dot_pages_pkg::dot_mode_field_t scan_mode_o, // effective dot mode
  output logic scan_active_o,                         // high in active part of slot
  output logic [1:0] scan_switch_line_o,              // switch line 0..2
  output logic [1:0] scan_sub_slot_o                  // sub-slot 0..3
);
  import dot_pages_pkg::*;

  typedef enum logic {SLOT_ACTIVE, SLOT_GAP} slot_state_t;

  logic [7:0] onoff_mem_ff [ONOFF_N];
  logic [7:0] open_mem_ff [FLAG_N];
  logic [7:0] short_mem_ff [FLAG_N];
  logic [7:0] duty_mem_ff [DOT_BYTES_N];
  logic [1:0] mode_mem_ff [DOT_BYTES_N];
  logic [7:0] page_ff;
  logic [7:0] lock_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] nxt_rdata;
  logic wr_onoff, wr_duty, wr_mode;
  logic [7:0] scan_onoff_ff, scan_duty_ff;
  dot_mode_field_t scan_mode_ff;
  slot_state_t slot_state_ff;
  logic [15:0] slot_cnt_ff;
  logic [3:0] slot_idx_ff;
  logic [7:0] open_off, short_off;

  assign open_off = reg_req_i.addr - OPEN_FIRST;
  assign short_off = reg_req_i.addr - SHORT_FIRST;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // flag ranges get no write enable at all, so they cannot be disturbed
  assign wr_onoff = reg_req_i.wr && page_ff == LED_CONTROL_PAGE &&
                    reg_req_i.addr <= ONOFF_LAST;
  assign wr_duty = reg_req_i.wr && page_ff == DUTY_PAGE &&
                   reg_req_i.addr <= DUTY_LAST;
  assign wr_mode = reg_req_i.wr && page_ff == BREATH_SELECT_PAGE &&
                   reg_req_i.addr <= DUTY_LAST;

  // ---------------------------------------------------------------
  // page selector and its lock
  // ---------------------------------------------------------------
  // the key is consumed by the first selector write; a write while locked leaves the lock value as it is
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_ff <= LOCK_RESET;
    end else if (reg_req_i.wr && reg_req_i.addr == PAGE_SELECTOR_LOCK_ADDR) begin
      lock_ff <= reg_req_i.wdata;
    end else if (reg_req_i.wr && reg_req_i.addr == PAGE_SELECTOR_ADDR &&
                 lock_ff == UNLOCK_KEY) begin
      lock_ff <= LOCK_RESET;
    end
  end

  // reserved page codes are stored but reach no bank
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      page_ff <= PAGE_RESET;
    end else if (reg_req_i.wr && reg_req_i.addr == PAGE_SELECTOR_ADDR &&
                 lock_ff == UNLOCK_KEY) begin
      page_ff <= reg_req_i.wdata;
    end
  end

  // ---------------------------------------------------------------
  // write-only banks
  // ---------------------------------------------------------------
  // a set bit enables that dot drive path, a clear bit disables it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ONOFF_N; i++) onoff_mem_ff[i] <= ONOFF_RESET;
    end else if (wr_onoff) begin
      onoff_mem_ff[reg_req_i.addr[4:0]] <= reg_req_i.wdata;
    end
  end

  // each byte is an independent 8-bit quarter-slot contribution
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DOT_BYTES_N; i++) duty_mem_ff[i] <= DUTY_RESET;
    end else if (wr_duty) begin
      duty_mem_ff[reg_req_i.addr] <= reg_req_i.wdata;
    end
  end

  // upper six bits are dropped on write
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DOT_BYTES_N; i++) mode_mem_ff[i] <= MODE_PWM;
    end else if (wr_mode) begin
      mode_mem_ff[reg_req_i.addr] <= reg_req_i.wdata[MODE_MSB:0];
    end
  end

  // ---------------------------------------------------------------
  // fault flags
  // ---------------------------------------------------------------
  // only a detection run updates the flags; they hold until the next run
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < FLAG_N; i++) begin
        open_mem_ff[i] <= FLAG_RESET;
        short_mem_ff[i] <= FLAG_RESET;
      end
    end else if (fault_rpt_i.valid && 32'(fault_rpt_i.idx) < FLAG_N) begin
      open_mem_ff[fault_rpt_i.idx] <= {fault_rpt_i.open[3], 1'b0, fault_rpt_i.open[2], 1'b0,
                                       fault_rpt_i.open[1], 1'b0, fault_rpt_i.open[0],
                                       1'b0};
      short_mem_ff[fault_rpt_i.idx] <= {fault_rpt_i.short[3], 1'b0, fault_rpt_i.short[2],
                                        1'b0, fault_rpt_i.short[1], 1'b0,
                                        fault_rpt_i.short[0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // write-only and reserved locations read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_req_i.addr == PAGE_SELECTOR_LOCK_ADDR) begin
      nxt_rdata = lock_ff;
    end else if (page_ff == LED_CONTROL_PAGE && reg_req_i.addr >= OPEN_FIRST &&
                 reg_req_i.addr <= OPEN_LAST) begin
      nxt_rdata = open_mem_ff[open_off[4:0]] & FLAG_MASK;
    end else if (page_ff == LED_CONTROL_PAGE && reg_req_i.addr >= SHORT_FIRST &&
                 reg_req_i.addr <= SHORT_LAST) begin
      nxt_rdata = short_mem_ff[short_off[4:0]] & FLAG_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_req_i.rd;
      if (reg_req_i.rd) rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign page_selector_o = page_ff;

  // ---------------------------------------------------------------
  // scan fetch port
  // ---------------------------------------------------------------
  // the scan engine sums a dot's eight duty bytes itself: current follows
  // that sum over 256 times half the source current times the slot duty
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      scan_onoff_ff <= 8'h00;
      scan_duty_ff <= 8'h00;
      scan_mode_ff <= MODE_PWM;
    end else begin
      scan_onoff_ff <= (32'(scan_idx_i) < ONOFF_N) ? onoff_mem_ff[scan_idx_i[4:0]] : 8'h00;
      scan_duty_ff <= (scan_idx_i <= DUTY_LAST) ? duty_mem_ff[scan_idx_i] : 8'h00;
      if (!breath_en_i || scan_idx_i > DUTY_LAST) begin
        scan_mode_ff <= MODE_PWM;
      end else begin
        scan_mode_ff <= dot_mode_field_t'(mode_mem_ff[scan_idx_i]);
      end
    end
  end

  assign scan_onoff_o = scan_onoff_ff;
  assign scan_duty_o = scan_duty_ff;
  assign scan_mode_o = scan_mode_ff;

  // ---------------------------------------------------------------
  // scan slot timer
  // ---------------------------------------------------------------
  // twelve slots of active time plus gap give each dot a 1/12.75 duty
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      slot_state_ff <= SLOT_ACTIVE;
      slot_cnt_ff <= 16'h0000;
      slot_idx_ff <= 4'h0;
    end else begin
      case (slot_state_ff)
        SLOT_ACTIVE: begin
          if (32'(slot_cnt_ff) == ACTIVE_CYCLES - 1) begin
            slot_state_ff <= SLOT_GAP;
            slot_cnt_ff <= 16'h0000;
          end else begin
            slot_cnt_ff <= slot_cnt_ff + 16'h0001;
          end
        end
        SLOT_GAP: begin
          if (32'(slot_cnt_ff) == GAP_CYC - 1) begin
            slot_state_ff <= SLOT_ACTIVE;
            slot_cnt_ff <= 16'h0000;
            slot_idx_ff <= (slot_idx_ff == SLOT_LAST) ? 4'h0 : slot_idx_ff + 4'h1;
          end else begin
            slot_cnt_ff <= slot_cnt_ff + 16'h0001;
          end
        end
        default: begin
          slot_state_ff <= SLOT_ACTIVE;
          slot_cnt_ff <= 16'h0000;
        end
      endcase
    end
  end

  assign scan_active_o = (slot_state_ff == SLOT_ACTIVE);
  assign scan_switch_line_o = slot_idx_ff[3:2];
  assign scan_sub_slot_o = slot_idx_ff[1:0];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // the gap bound check leans on the timer's own counter; the gap length check repeats only 8 cycles
  sequence s_unlock_then_select;
    (reg_req_i.wr && reg_req_i.addr == PAGE_SELECTOR_ADDR && lock_ff == UNLOCK_KEY);
  endsequence

  sequence s_gap_entry;
    $rose(slot_state_ff == SLOT_GAP);
  endsequence

  a_lock_one_shot: assert property (s_unlock_then_select |=> lock_ff == LOCK_RESET &&
      page_ff == $past(reg_req_i.wdata)) else $error("selector write did not consume key");
  a_locked_select: assert property (reg_req_i.wr &&
      reg_req_i.addr == PAGE_SELECTOR_ADDR && lock_ff != UNLOCK_KEY |=> $stable(page_ff))
      else $error("locked selector changed");
  a_flag_hold: assert property (!fault_rpt_i.valid |=>
      open_mem_ff[0] == $past(open_mem_ff[0]) && short_mem_ff[16] == $past(short_mem_ff[16]))
      else $error("flag moved without run");
  a_flag_odd_bits: assert property (reg_rvalid_o &&
      $past(page_ff) == LED_CONTROL_PAGE && $past(reg_req_i.addr) >= OPEN_FIRST &&
      $past(reg_req_i.addr) <= SHORT_LAST |-> (reg_rdata_o & ~FLAG_MASK) == 8'h00)
      else $error("even flag bit read nonzero");
  a_short_read: assert property (reg_req_i.rd && page_ff == LED_CONTROL_PAGE &&
      reg_req_i.addr == SHORT_FIRST |=> reg_rvalid_o &&
      reg_rdata_o == ($past(short_mem_ff[0]) & FLAG_MASK))
      else $error("short flag readback wrong");
  a_wo_reads_zero: assert property (reg_req_i.rd && reg_req_i.addr <= ONOFF_LAST |=>
      reg_rdata_o == 8'h00) else $error("write-only byte read back");
  a_onoff_store: assert property (wr_onoff && reg_req_i.addr == ONOFF_LAST |=>
      onoff_mem_ff[ONOFF_N - 1] == $past(reg_req_i.wdata)) else $error("on/off write lost");
  a_pwm_forced: assert property (!breath_en_i |=> scan_mode_o == MODE_PWM)
      else $error("breath mode while disabled");
  a_mode_pass: assert property (breath_en_i && scan_idx_i <= DUTY_LAST |=>
      scan_mode_o == dot_mode_field_t'($past(mode_mem_ff[scan_idx_i])))
      else $error("mode not passed");
  a_gap_length: assert property (s_gap_entry |-> (slot_state_ff == SLOT_GAP) [*8])
      else $error("scan gap too short");
  a_gap_bound: assert property (slot_state_ff == SLOT_GAP |->
      32'(slot_cnt_ff) < GAP_CYC) else $error("scan gap overran");
  a_slot_range: assert property (slot_idx_ff <= SLOT_LAST)
      else $error("slot index past last slot");
  a_duty_store: assert property (wr_duty && reg_req_i.addr == 8'h00 |=>
      duty_mem_ff[0] == $past(reg_req_i.wdata)) else $error("duty write lost");
  a_mode_trim: assert property (wr_mode && reg_req_i.addr == 8'h00 |=>
      mode_mem_ff[0] == $past(reg_req_i.wdata[MODE_MSB:0]))
      else $error("mode field not trimmed");
  a_rvalid_pulse: assert property (reg_req_i.rd |=> reg_rvalid_o)
      else $error("read answer missing");

endmodule
`default_nettype wire

// ### design/dot_pages_pkg.sv
/*
  Package for the dot control register pages: page codes, register offsets,
  field positions, reset values, scan timing and the register request struct.
  Assumes one 100 MHz core clock shared by every user of the package.
*/
package dot_pages_pkg;

  // ---------------------------------------------------------------
  // page selector codes and the lock key
  // ---------------------------------------------------------------
  localparam logic [7:0] LED_CONTROL_PAGE = 8'h00;
  localparam logic [7:0] DUTY_PAGE = 8'h01;
  localparam logic [7:0] BREATH_SELECT_PAGE = 8'h02;
  localparam logic [7:0] FUNCTION_PAGE = 8'h03;
  localparam logic [7:0] PAGE_SELECTOR_ADDR = 8'hFD;
  localparam logic [7:0] PAGE_SELECTOR_LOCK_ADDR = 8'hFE;
  localparam logic [7:0] UNLOCK_KEY = 8'hC5;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // bank ranges within the pages
  // ---------------------------------------------------------------
  localparam logic [7:0] ONOFF_FIRST = 8'h00;
  localparam logic [7:0] ONOFF_LAST = 8'h16;
  localparam logic [7:0] OPEN_FIRST = 8'h18;
  localparam logic [7:0] OPEN_LAST = 8'h28;
  localparam logic [7:0] SHORT_FIRST = 8'h30;
  localparam logic [7:0] SHORT_LAST = 8'h40;
  localparam logic [7:0] DUTY_LAST = 8'hB7;
  localparam int ONOFF_N = 23;
  localparam int FLAG_N = 17;
  localparam int DOT_BYTES_N = 184;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAG_MASK = 8'hAA;   // flags sit in D7, D5, D3, D1
  localparam logic [7:0] ONOFF_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam int MODE_MSB = 1;

  // ---------------------------------------------------------------
  // scan timing: 128 us active plus 8 us gap, 3 switch lines x 4 sub-slots
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int ACTIVE_US = 128;
  localparam int GAP_US = 8;
  localparam int ACTIVE_CYC = ACTIVE_US * CLK_MHZ;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int SWITCH_LINES = 3;
  localparam int SUB_SLOTS = 4;
  localparam logic [3:0] SLOT_LAST = 4'hB;   // 3 x 4 slots, counted 0..11

  typedef enum logic [1:0] {
    MODE_PWM,
    BREATH_PROFILE_ONE,
    BREATH_PROFILE_TWO,
    BREATH_PROFILE_THREE
  } dot_mode_field_t;

  typedef struct packed {
    logic wr;          // one-cycle write strobe
    logic rd;          // one-cycle read strobe
    logic [7:0] addr;  // register address within the selected page
    logic [7:0] wdata; // write data
  } reg_req_t;

  typedef struct packed {
    logic valid;       // one-cycle result strobe of a detection run
    logic [4:0] idx;   // flag byte index, 0..16
    logic [3:0] open;  // open results for D7, D5, D3, D1
    logic [3:0] short; // short results for D7, D5, D3, D1
  } fault_rpt_t;

endpackage

// ### tb/host_port_model.sv
/*
  Host side model: issues byte strobes toward the dot pages and collects
  read answers. Assumes the one-cycle strobe contract of the register port
  and a single core clock shared with the pages.
*/
`timescale 1ns/1ns
`default_nettype none

module host_port_model (
  input wire logic core_clk_i,                  // core clock
  input wire logic [7:0] reg_rdata_i,           // read data from the pages
  input wire logic reg_rvalid_i,                // read data valid pulse
  output var dot_pages_pkg::reg_req_t reg_req_o // byte strobes toward the pages
);
  import dot_pages_pkg::*;

  initial reg_req_o = '0;

  // one write strobe, then an idle cycle so two strobes never merge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_i) reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge core_clk_i) reg_req_o <= '0;
    #1; // let the write land before the caller looks at any output
  endtask

  // read strobe; the answer is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge core_clk_i) reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge core_clk_i) reg_req_o <= '0;
    #1;
    ok = reg_rvalid_i;
    data = reg_rdata_i;
  endtask

  // unlock first, since the selector refuses a bare write
  task automatic select_page(input logic [7:0] page);
    wr(PAGE_SELECTOR_LOCK_ADDR, UNLOCK_KEY);
    wr(PAGE_SELECTOR_ADDR, page);
  endtask

  // same value into all eight bytes of one dot, never a partial dot
  task automatic dot_bytes(input logic [7:0] base, input logic [7:0] val);
    logic [7:0] offs [8];
    offs = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h20, 8'h21, 8'h30, 8'h31};
    foreach (offs[i]) wr(base + offs[i], val);
  endtask
endmodule

`default_nettype wire

// ### tb/tb_led_matrix_dot_control_pages.sv
/*
  Self-checking bench for the dot control pages: reset state, selector lock,
  on/off, flag, duty and mode banks, reserved pages and the scan slot timer.
  Assumes the host model drives the register port and a short active slot.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_led_matrix_dot_control_pages;
  import dot_pages_pkg::*;

  localparam int ACT = 16; // short active slot keeps the run brief
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t reg_req;
  fault_rpt_t fault_rpt = '0;
  logic breath_en = 1'b0;
  logic [7:0] s_idx = 8'h00;
  logic [7:0] rdata, page_sel, s_onoff, s_duty;
  logic rvalid, s_active;
  logic [1:0] s_line, s_sub;
  dot_mode_field_t s_mode;
  int bad_count = 0;
  int compares = 0;

  // ---------------------------------------------------------------
  // clock, design and host
  // ---------------------------------------------------------------
  initial forever #5 core_clk = ~core_clk;

  dot_pages #(.ACTIVE_CYCLES(ACT)) dut (
    .core_clk_i(core_clk), .rst_i(rst), .reg_req_i(reg_req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .page_selector_o(page_sel), .fault_rpt_i(fault_rpt),
    .breath_en_i(breath_en), .scan_idx_i(s_idx), .scan_onoff_o(s_onoff),
    .scan_duty_o(s_duty), .scan_mode_o(s_mode), .scan_active_o(s_active),
    .scan_switch_line_o(s_line), .scan_sub_slot_o(s_sub));

  host_port_model host (.core_clk_i(core_clk), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid), .reg_req_o(reg_req));

  // ---------------------------------------------------------------
  // shared checks
  // ---------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    host.rd(addr, v, ok);
    check8("read valid", 8'h01, {7'h00, ok});
    check8($sformatf("read of %h", addr), exp, v);
  endtask

  // fetch one index through the scan port; result shows one cycle later
  task automatic scan(input logic [7:0] idx, input logic ben);
    @(posedge core_clk) begin s_idx <= idx; breath_en <= ben; end
    @(posedge core_clk);
    #1;
  endtask

  task automatic post_fault(input logic [4:0] idx, input logic [3:0] op, input logic [3:0] sh);
    @(posedge core_clk) fault_rpt <= '{valid: 1'b1, idx: idx, open: op, short: sh};
    @(posedge core_clk) fault_rpt <= '0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check8("page after reset", PAGE_RESET, page_sel);
    rchk(PAGE_SELECTOR_LOCK_ADDR, LOCK_RESET);
    scan(8'h16, 1'b1);
    check8("onoff after reset", ONOFF_RESET, s_onoff);
    check8("duty after reset", DUTY_RESET, s_duty);
    check8("mode after reset", 8'h00, {6'h00, s_mode});
  endtask

  task automatic t_onoff_flags();
    host.select_page(LED_CONTROL_PAGE);
    host.wr(8'h00, 8'hFF);
    host.wr(ONOFF_LAST, 8'hA5);
    host.wr(8'h17, 8'hFF);
    scan(8'h00, 1'b0);
    check8("onoff first", 8'hFF, s_onoff);
    scan(ONOFF_LAST, 1'b0);
    check8("onoff last", 8'hA5, s_onoff);
    scan(8'h17, 1'b0);
    check8("onoff past bank", 8'h00, s_onoff);
    rchk(8'h00, 8'h00);
    post_fault(5'd0, 4'b1000, 4'b0101);
    post_fault(5'd16, 4'b1111, 4'b1111);
    post_fault(5'd17, 4'b0000, 4'b0000);
    rchk(OPEN_FIRST, 8'h80);
    rchk(SHORT_FIRST, 8'h22);
    rchk(OPEN_LAST, FLAG_MASK);
    rchk(SHORT_LAST, FLAG_MASK);
    host.wr(OPEN_FIRST, 8'hFF);
    host.wr(SHORT_FIRST, 8'h00);
    rchk(OPEN_FIRST, 8'h80);
    rchk(SHORT_FIRST, 8'h22);
    rchk(8'h17, 8'h00);
  endtask

  task automatic t_lock();
    host.wr(PAGE_SELECTOR_ADDR, DUTY_PAGE);
    check8("page while locked", LED_CONTROL_PAGE, page_sel);
    host.wr(PAGE_SELECTOR_LOCK_ADDR, 8'h12);
    rchk(PAGE_SELECTOR_LOCK_ADDR, 8'h12);
    host.wr(PAGE_SELECTOR_ADDR, DUTY_PAGE);
    check8("page on wrong key", LED_CONTROL_PAGE, page_sel);
    host.select_page(DUTY_PAGE);
    check8("page after unlock", DUTY_PAGE, page_sel);
    rchk(PAGE_SELECTOR_LOCK_ADDR, LOCK_RESET);
    host.wr(PAGE_SELECTOR_ADDR, BREATH_SELECT_PAGE);
    check8("second write refused", DUTY_PAGE, page_sel);
  endtask

  task automatic t_duty();
    host.dot_bytes(8'h00, 8'h80);
    host.wr(DUTY_LAST, 8'h5A);
    host.wr(ONOFF_LAST, 8'h11);
    scan(8'h31, 1'b0);
    check8("duty of dot byte", 8'h80, s_duty);
    scan(ONOFF_LAST, 1'b0);
    check8("onoff untouched", 8'hA5, s_onoff);
    check8("duty at onoff offset", 8'h11, s_duty);
    scan(DUTY_LAST, 1'b0);
    check8("duty last", 8'h5A, s_duty);
    scan(8'hB8, 1'b0);
    check8("duty past bank", 8'h00, s_duty);
  endtask

  // each mode code on its own dot, then the global enable forced off
  task automatic t_mode();
    host.select_page(BREATH_SELECT_PAGE);
    for (int m = 0; m < 4; m++) host.dot_bytes(8'(2 * m), {6'h3F, 2'(m)});
    for (int m = 0; m < 4; m++) begin
      scan(8'(2 * m + 'h31), 1'b1);
      check8("mode with breathing", 8'(m), {6'h00, s_mode});
      scan(8'(2 * m + 'h31), 1'b0);
      check8("mode forced", 8'h00, {6'h00, s_mode});
    end
    scan(8'h31, 1'b1);
    check8("duty on mode page", 8'h80, s_duty);
  endtask

  task automatic t_reserved();
    host.select_page(8'h05);
    check8("reserved page code", 8'h05, page_sel);
    host.wr(8'h00, 8'h33);
    scan(8'h00, 1'b0);
    check8("onoff on reserved", 8'hFF, s_onoff);
    check8("duty on reserved", 8'h80, s_duty);
  endtask

  task automatic t_timer();
    int n;
    logic [3:0] slot0;
    n = 0;
    while (s_active !== 1'b1 && n < 3000) begin @(posedge core_clk); #1; n++; end
    while (s_active === 1'b1 && n < 3000) begin @(posedge core_clk); #1; n++; end
    slot0 = {s_line, s_sub};
    n = 0;
    while (s_active === 1'b0 && n < 3000) begin @(posedge core_clk); #1; n++; end
    check8("gap cycles", 8'(GAP_CYC / 4), 8'(n / 4));
    check8("gap cycles low bits", 8'(GAP_CYC % 4), 8'(n % 4));
    check8("slot advance", (slot0 == SLOT_LAST) ? 8'h00 : 8'(slot0 + 1), {4'h0, s_line, s_sub});
    n = 0;
    while (s_active === 1'b1 && n < 3000) begin @(posedge core_clk); #1; n++; end
    check8("active cycles", 8'(ACT), 8'(n));
  endtask

  // ---------------------------------------------------------------
  // run and verdict
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_onoff_flags();
    t_lock();
    t_duty();
    t_mode();
    t_reserved();
    t_timer();
    wrap_up();
  end

  // the whole sequence needs well under 10000 cycles
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
